// ---- rtcxpc_core.sv ----
`timescale 1ns/1ns
module rtcxpc_core
    import rtcxpc_pkg::*;
#(
    parameter int UPDATE_LEAD = UPDATE_LEAD_CYCLES,
    parameter int RAM_BYTES   = 242
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ale,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       cs_n,
    input  wire logic [7:0] ad_in,
    output logic      [7:0] ad_out,
    output logic            ad_oe_n,
    input  wire logic       aux_battery_ok,
    input  wire logic       update_request,
    input  wire logic       update_done,
    input  wire logic       wakeup_event,
    input  wire logic       kickstart_in,
    input  wire logic       ram_clear_in,
    input  wire logic       main_supply_ok,
    input  wire logic       osc_32k,
    output logic            power_enable_out,
    output logic            power_enable_oe_n,
    output logic            irq_out,
    output logic            irq_oe_n,
    output logic            square_wave_out,
    output logic            aux_battery_supply,
    output logic            xtal_load_select,
    output logic            ram_clear_busy,
    output logic            update_start
);

    if (UPDATE_LEAD < 1 || RAM_BYTES < 1 || RAM_BYTES > 256) begin : g_param_check
        $error("rtcxpc_core: unsupported parameter value");
    end

    // --------------------------------------------------------------
    // Host bus: address latch and strobes
    // --------------------------------------------------------------
    logic [7:0] stack [4];
    logic       ale_q;
    logic       wr_q;
    logic       bank_select;
    logic       wr_pulse;
    logic       ale_fall;

    assign ale_fall = ale_q && !ale;
    assign wr_pulse = wr_q && wr_n && !cs_n;

    always_ff @(posedge clock) begin
        if (rst) begin
            ale_q <= 1'b0;
            wr_q  <= 1'b0;
        end else begin
            ale_q <= ale;
            wr_q  <= !wr_n && !cs_n;
        end
    end

    // Slot 0 is the current address; every latch shifts the history down
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                stack[i] <= RST_ADDR;
            end
        end else if (ale_fall) begin
            stack[0] <= ad_in;
            for (int i = 1; i < 4; i++) begin
                stack[i] <= stack[i-1];
            end
        end
    end

    // Only the bank bit of the oscillator register is kept in this block
    always_ff @(posedge clock) begin
        if (rst) begin
            bank_select <= 1'b0;
        end else if (wr_pulse && stack[0] == OFS_OSC_CTRL) begin
            bank_select <= ad_in[BIT_BANK_SELECT];
        end
    end

    function automatic logic ext_hit(input logic [7:0] a, input logic [7:0] ofs, input logic b);
        ext_hit = b && (a == ofs);
    endfunction

    logic wr_flags;
    logic wr_feature;
    assign wr_flags   = wr_pulse && ext_hit(stack[0], OFS_FLAGS, bank_select);
    assign wr_feature = wr_pulse && ext_hit(stack[0], OFS_FEATURE, bank_select);

    // --------------------------------------------------------------
    // Feature register
    // --------------------------------------------------------------
    logic [7:0] feature;

    always_ff @(posedge clock) begin
        if (rst) begin
            feature <= RST_FEATURE;
        end else begin
            if (wr_feature) begin
                feature <= ad_in;
            end
            if (main_supply_ok) begin
                feature[BIT_OSC_OUT_EN] <= 1'b1;
            end
        end
    end

    assign aux_battery_supply = feature[BIT_AUX_BATT_EN];
    assign xtal_load_select   = feature[BIT_XTAL_SELECT];
    assign square_wave_out    = feature[BIT_OSC_OUT_EN] && osc_32k;

    // --------------------------------------------------------------
    // Input edge detection
    // --------------------------------------------------------------
    logic kick_q;
    logic ram_clear_in_q;
    logic kick_fall;
    logic ram_clear_in_fall;

    always_ff @(posedge clock) begin
        if (rst) begin
            kick_q <= 1'b1;
            ram_clear_in_q <= 1'b1;
        end else begin
            kick_q <= kickstart_in;
            ram_clear_in_q <= ram_clear_in;
        end
    end

    assign kick_fall = kick_q && !kickstart_in;
    assign ram_clear_in_fall = ram_clear_in_q && !ram_clear_in && feature[BIT_RAM_CLEAR_EN];

    // --------------------------------------------------------------
    // User RAM clear sequencer
    // --------------------------------------------------------------
    // The RAM itself lives outside; this only times a walk over every byte and flags the end
    logic [7:0] clr_addr;
    logic       clr_done;

    always_ff @(posedge clock) begin
        if (rst) begin
            ram_clear_busy <= 1'b0;
            clr_addr       <= 8'h00;
            clr_done       <= 1'b0;
        end else begin
            clr_done <= 1'b0;
            if (!ram_clear_busy && ram_clear_in_fall) begin
                ram_clear_busy <= 1'b1;
                clr_addr       <= 8'h00;
            end else if (ram_clear_busy) begin
                if (clr_addr == 8'(RAM_BYTES - 1)) begin
                    ram_clear_busy <= 1'b0;
                    clr_done       <= 1'b1;
                end else begin
                    clr_addr <= clr_addr + 8'h01;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Flag register
    // --------------------------------------------------------------
    logic [7:0] flags;
    logic       wake_armed;
    logic       kick_armed;

    assign wake_armed = flags[BIT_WAKEUP_FLAG] && feature[BIT_WAKEUP_IRQ_EN];
    assign kick_armed = flags[BIT_KICKSTART_FLAG] && feature[BIT_KICK_IRQ_EN];

    // Hardware set wins over a host clear written in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            flags <= RST_FLAGS;
        end else begin
            if (wr_flags) begin
                flags[BIT_RSVD_HI]        <= ad_in[BIT_RSVD_HI];
                flags[BIT_RSVD_LO]        <= ad_in[BIT_RSVD_LO];
                flags[BIT_POWER_ACTIVE]   <= ad_in[BIT_POWER_ACTIVE];
                flags[BIT_RAM_CLEAR_FLAG] <= ad_in[BIT_RAM_CLEAR_FLAG];
                flags[BIT_WAKEUP_FLAG]    <= ad_in[BIT_WAKEUP_FLAG];
                flags[BIT_KICKSTART_FLAG] <= ad_in[BIT_KICKSTART_FLAG];
            end
            if (clr_done) begin
                flags[BIT_RAM_CLEAR_FLAG] <= 1'b1;
            end
            if (wakeup_event) begin
                flags[BIT_WAKEUP_FLAG] <= 1'b1;
            end
            if (kick_fall) begin
                flags[BIT_KICKSTART_FLAG] <= 1'b1;
            end
            if (wake_armed || kick_armed) begin
                flags[BIT_POWER_ACTIVE] <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Update-in-progress tracking
    // --------------------------------------------------------------
    rtcxpc_upd_t upd_state;
    logic [31:0] lead_cnt;

    always_ff @(posedge clock) begin
        if (rst) begin
            upd_state    <= RTCXPC_IDLE;
            lead_cnt     <= 32'h0;
            update_start <= 1'b0;
        end else begin
            update_start <= 1'b0;
            unique case (upd_state)
                RTCXPC_IDLE: begin
                    if (update_request) begin
                        upd_state <= RTCXPC_LEAD;
                        lead_cnt  <= 32'(UPDATE_LEAD - 1);
                    end
                end
                RTCXPC_LEAD: begin
                    if (lead_cnt == 32'h0) begin
                        upd_state    <= RTCXPC_UPDATE;
                        update_start <= 1'b1;
                    end else begin
                        lead_cnt <= lead_cnt - 32'h1;
                    end
                end
                RTCXPC_UPDATE: begin
                    if (update_done) begin
                        upd_state <= RTCXPC_IDLE;
                    end
                end
                default: upd_state <= RTCXPC_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Output pins
    // --------------------------------------------------------------
    logic irq_pending;
    logic pwr_drive;

    assign irq_pending = wake_armed || kick_armed
                      || (flags[BIT_RAM_CLEAR_FLAG] && feature[BIT_RC_IRQ_EN]);

    // Without main supply the pin stays active only when hold is selected or an
    // enabled wake-up or kickstart is asking the system to power on
    assign pwr_drive = !flags[BIT_POWER_ACTIVE]
                    && (main_supply_ok || feature[BIT_PF_HOLD_SEL]
                        || wake_armed || kick_armed);

    always_ff @(posedge clock) begin
        if (rst) begin
            power_enable_oe_n <= 1'b1;
            irq_oe_n          <= 1'b1;
        end else begin
            power_enable_oe_n <= !pwr_drive;
            irq_oe_n          <= !(irq_pending && main_supply_ok);
        end
    end

    assign power_enable_out = 1'b0;
    assign irq_out          = 1'b0;

    // --------------------------------------------------------------
    // Read data
    // --------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (bank_select) begin
            unique case (stack[0])
                OFS_FLAGS: begin
                    rd_mux = flags;
                    rd_mux[BIT_AUX_BATTERY_OK] = aux_battery_ok;
                    rd_mux[BIT_UPDATE_IN_PROG] = (upd_state != RTCXPC_IDLE);
                end
                OFS_FEATURE:     rd_mux = feature;
                OFS_STACK_LOWER: rd_mux = stack[2];
                OFS_STACK_UPPER: rd_mux = stack[3];
                default:         rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ad_out  <= 8'h00;
            ad_oe_n <= 1'b1;
        end else begin
            ad_out  <= rd_mux;
            ad_oe_n <= rd_n || cs_n;
        end
    end

endmodule // rtcxpc_core

// ---- rtcxpc_pkg.sv ----
package rtcxpc_pkg;

    // --------------------------------------------------------------
    // Register offsets (extended bank; oscillator control decoded in either bank)
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_FLAGS       = 8'h4a;
    localparam logic [7:0] OFS_FEATURE     = 8'h4b;
    localparam logic [7:0] OFS_STACK_LOWER = 8'h4e;
    localparam logic [7:0] OFS_STACK_UPPER = 8'h4f;
    localparam logic [7:0] OFS_OSC_CTRL    = 8'h0a;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    // Flag register
    localparam int BIT_AUX_BATTERY_OK = 7;
    localparam int BIT_UPDATE_IN_PROG = 6;
    localparam int BIT_RSVD_HI        = 5;
    localparam int BIT_RSVD_LO        = 4;
    localparam int BIT_POWER_ACTIVE   = 3;
    localparam int BIT_RAM_CLEAR_FLAG = 2;
    localparam int BIT_WAKEUP_FLAG    = 1;
    localparam int BIT_KICKSTART_FLAG = 0;
    // Feature register
    localparam int BIT_AUX_BATT_EN    = 7;
    localparam int BIT_OSC_OUT_EN     = 6;
    localparam int BIT_XTAL_SELECT    = 5;
    localparam int BIT_RAM_CLEAR_EN   = 4;
    localparam int BIT_PF_HOLD_SEL    = 3;
    localparam int BIT_RC_IRQ_EN      = 2;
    localparam int BIT_WAKEUP_IRQ_EN  = 1;
    localparam int BIT_KICK_IRQ_EN    = 0;
    // Bank select bit inside the oscillator control register
    localparam int BIT_BANK_SELECT    = 4;

    // --------------------------------------------------------------
    // Reset values and timing
    // --------------------------------------------------------------
    localparam logic [7:0] RST_FLAGS      = 8'h08;
    localparam logic [7:0] RST_FEATURE    = 8'h40;
    localparam logic [7:0] RST_ADDR       = 8'h00;
    localparam int         CLOCK_MHZ      = 250;
    localparam int         UPDATE_LEAD_US = 122;
    localparam int         UPDATE_LEAD_CYCLES = UPDATE_LEAD_US * CLOCK_MHZ;

    typedef enum logic [1:0] {
        RTCXPC_IDLE    = 2'b00,
        RTCXPC_LEAD    = 2'b01,
        RTCXPC_UPDATE  = 2'b10
    } rtcxpc_upd_t;

endpackage

// ---- rtcxpc_props_properties.sv ----
`timescale 1ns/1ns
module rtcxpc_props #(
    parameter int UPDATE_LEAD = 8,
    parameter int RAM_BYTES   = 242
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic rd_n,
    input wire logic cs_n,
    input wire logic ad_oe_n,
    input wire logic osc_32k,
    input wire logic square_wave_out,
    input wire logic update_request,
    input wire logic update_start,
    input wire logic ram_clear_in,
    input wire logic ram_clear_busy,
    input wire logic main_supply_ok,
    input wire logic irq_oe_n,
    input wire logic power_enable_out,
    input wire logic irq_out
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    int lead_cnt;
    int busy_cnt;
    always_ff @(posedge clock) begin
        lead_cnt <= (rst || update_request) ? 0 : lead_cnt + 1;
    end
    always_ff @(posedge clock) begin
        busy_cnt <= ram_clear_busy ? busy_cnt + 1 : 0;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence rd_seq;
        !cs_n && !rd_n ##1 !cs_n && !rd_n;
    endsequence
    read_drive_a: assert property (rd_seq |-> !ad_oe_n)
        else $error("bus not driven in read");
    read_release_a: assert property ((rd_n || cs_n) [*2] |-> ad_oe_n)
        else $error("bus driven outside read");
    osc_gate_a: assert property (square_wave_out |-> osc_32k)
        else $error("square wave not from oscillator");
    // Request edge to start pulse edge spans exactly the lead count
    lead_time_a: assert property (update_start |-> lead_cnt == UPDATE_LEAD)
        else $error("update lead time wrong");
    start_pulse_a: assert property (update_start |=> !update_start)
        else $error("update start not a pulse");
    clear_start_a: assert property ($rose(ram_clear_busy) |-> $past(ram_clear_in, 2) && !$past(ram_clear_in))
        else $error("clear without input fall");
    clear_len_a: assert property ($fell(ram_clear_busy) |-> busy_cnt == RAM_BYTES)
        else $error("clear length wrong");
    irq_supply_a: assert property (!irq_oe_n |-> $past(main_supply_ok))
        else $error("interrupt without supply");
    od_data_a: assert property (!power_enable_out && !irq_out)
        else $error("open drain data not low");
endmodule // rtcxpc_props

// ---- rtcxpc_host.sv ----
`timescale 1ns/1ns
// Host on the multiplexed bus; all changes at the falling edge
module rtcxpc_host (
    input  wire logic       clock,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe_n,
    output logic            ale,
    output logic            rd_n,
    output logic            wr_n,
    output logic            cs_n,
    output logic      [7:0] ad_in
);
    initial begin
        {ale, rd_n, wr_n, cs_n} = 4'h7;
        ad_in = 8'h00;
    end
    task automatic latch(input logic [7:0] a);
        @(negedge clock) ale = 1'b1;
        ad_in = a;
        @(negedge clock) ale = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        latch(a);
        @(negedge clock) ad_in = d;
        {cs_n, wr_n} = 2'b00;
        @(negedge clock) wr_n = 1'b1;
        // Inverted data after release so a stale bus never matches
        @(negedge clock) cs_n = 1'b1;
        ad_in = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        latch(a);
        @(negedge clock) ad_in = ~a;
        {cs_n, rd_n} = 2'b00;
        repeat (2) @(negedge clock);
        d = ad_oe_n ? 8'hxx : ad_out;
        {cs_n, rd_n} = 2'b11;
    endtask
endmodule // rtcxpc_host

// ---- tb_rtc_extended_power_control.sv ----
`timescale 1ns/1ns
module tb_rtc_extended_power_control;
    import rtcxpc_pkg::*;
    localparam int LEAD = 8;
    localparam int NRAM = 16;
    logic       clock = 1'b0, rst = 1'b1, aux_battery_ok = 1'b1, update_request = 1'b0;
    logic       update_done = 1'b0, wakeup_event = 1'b0, kickstart_in = 1'b1;
    logic       ram_clear_in = 1'b1, main_supply_ok = 1'b1, osc_32k = 1'b0;
    logic       ale, rd_n, wr_n, cs_n, ad_oe_n, power_enable_out, power_enable_oe_n;
    logic       irq_out, irq_oe_n, square_wave_out, aux_battery_supply, xtal_load_select;
    logic       ram_clear_busy, update_start;
    logic [7:0] ad_in, ad_out, rv, res;
    logic [7:0] q[$];
    int         fails = 0, n_tests = 0, cycles = 0;
    integer     seed = 32'h0d86;
    rtcxpc_host u_host (.clock, .ad_out, .ad_oe_n, .ale, .rd_n, .wr_n, .cs_n, .ad_in);
    rtcxpc_core #(.UPDATE_LEAD(LEAD), .RAM_BYTES(NRAM)) u_dut (
        .clock, .rst, .ale, .rd_n, .wr_n, .cs_n, .ad_in, .ad_out, .ad_oe_n, .aux_battery_ok,
        .update_request, .update_done, .wakeup_event, .kickstart_in, .ram_clear_in,
        .main_supply_ok, .osc_32k, .power_enable_out, .power_enable_oe_n, .irq_out, .irq_oe_n,
        .square_wave_out, .aux_battery_supply, .xtal_load_select, .ram_clear_busy, .update_start
    );
    always #2 clock = ~clock;
    always @(negedge clock) osc_32k <= ~osc_32k;
    always @(posedge clock) begin
        cycles++;
        if (cycles > 5000) begin
            fails++;
            finish_test();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Every latch is recorded: the queue is the stack model
    task automatic wrx(input logic [7:0] a, input logic [7:0] d);
        u_host.wr(a, d);
        q.push_back(a);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.rd(a, v);
        q.push_back(a);
        chk(v, e);
    endtask
    // Pin outputs are registered behind the register write
    task automatic pchk(input logic p, input logic i);
        repeat (2) @(negedge clock);
        chk({6'h0, power_enable_oe_n, irq_oe_n}, {6'h0, p, i});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clock);
        rst = 1'b0;
        rchk(OFS_FLAGS, 8'h00);
        wrx(OFS_OSC_CTRL, 8'h10);
        rchk(OFS_FLAGS, RST_FLAGS | 8'h80);
        aux_battery_ok = 1'b0;
        rchk(OFS_FLAGS, RST_FLAGS);
        rchk(8'h37, 8'h00);
        $display("test reset done");
        rv = 8'($random(seed));
        u_host.latch(rv);
        q.push_back(rv);
        wrx(OFS_OSC_CTRL, 8'h10);
        rchk(OFS_STACK_LOWER, rv);
        wrx(OFS_STACK_UPPER, 8'hff);
        rchk(OFS_STACK_UPPER, q[$-2]);
        $display("test stack done");
        res = 8'($random(seed)) & 8'h30;
        wrx(OFS_FLAGS, res | 8'h0a);
        rchk(OFS_FLAGS, res | 8'h0a);
        pchk(1'b1, 1'b1);
        wrx(OFS_FEATURE, 8'h42);
        pchk(1'b0, 1'b0);
        rchk(OFS_FLAGS, res | 8'h02);
        wrx(OFS_FLAGS, res);
        pchk(1'b0, 1'b1);
        wrx(OFS_FLAGS, res | 8'h08);
        pchk(1'b1, 1'b1);
        for (int en = 1; en >= 0; en--) begin
            wrx(OFS_FEATURE, 8'h40 | 8'(en));
            @(negedge clock) kickstart_in = 1'b0;
            repeat (2) @(negedge clock);
            kickstart_in = 1'b1;
            pchk(en == 0, en == 0);
            rchk(OFS_FLAGS, res | (en ? 8'h01 : 8'h09));
            wrx(OFS_FLAGS, res);
            wrx(OFS_FLAGS, res | 8'h08);
        end
        $display("test flags done");
        wrx(OFS_FEATURE, 8'h42);
        main_supply_ok = 1'b0;
        @(negedge clock) wakeup_event = 1'b1;
        @(negedge clock) wakeup_event = 1'b0;
        pchk(1'b0, 1'b1);
        main_supply_ok = 1'b1;
        pchk(1'b0, 1'b0);
        wrx(OFS_FLAGS, res);
        wrx(OFS_FEATURE, 8'h48);
        main_supply_ok = 1'b0;
        pchk(1'b0, 1'b1);
        wrx(OFS_FEATURE, 8'h40);
        pchk(1'b1, 1'b1);
        main_supply_ok = 1'b1;
        wrx(OFS_FLAGS, res | 8'h08);
        $display("test supply done");
        for (int en = 0; en < 2; en++) begin
            wrx(OFS_FEATURE, en ? 8'h54 : 8'h44);
            @(negedge clock) ram_clear_in = 1'b0;
            repeat (2) @(negedge clock);
            chk({7'h0, ram_clear_busy}, 8'(en));
            for (int i = 0; i < 100 && ram_clear_busy !== 1'b0; i++) @(negedge clock);
            ram_clear_in = 1'b1;
            pchk(1'b1, en == 0);
            rchk(OFS_FLAGS, res | (en ? 8'h0c : 8'h08));
        end
        wrx(OFS_FLAGS, res | 8'h08);
        pchk(1'b1, 1'b1);
        wrx(OFS_FLAGS, res | 8'h0c);
        pchk(1'b1, 1'b0);
        wrx(OFS_FLAGS, res | 8'h08);
        $display("test clear done");
        @(negedge clock) update_request = 1'b1;
        @(negedge clock) update_request = 1'b0;
        rchk(OFS_FLAGS, res | 8'h48);
        for (int i = 0; i < 50 && update_start !== 1'b1; i++) @(negedge clock);
        chk({7'h0, update_start}, 8'h01);
        @(negedge clock) update_done = 1'b1;
        @(negedge clock) update_done = 1'b0;
        rchk(OFS_FLAGS, res | 8'h08);
        $display("test update done");
        // Without supply the oscillator output enable is not forced, so it stays as written
        main_supply_ok = 1'b0;
        wrx(OFS_FEATURE, 8'ha0);
        @(posedge clock);
        chk({5'h0, aux_battery_supply, xtal_load_select, square_wave_out}, 8'h06);
        rchk(OFS_FEATURE, 8'ha0);
        @(negedge clock) main_supply_ok = 1'b1;
        rchk(OFS_FEATURE, 8'he0);
        repeat (2) @(posedge clock) chk({7'h0, square_wave_out}, {7'h0, osc_32k});
        $display("test feature done");
        finish_test();
    end
endmodule // tb_rtc_extended_power_control

bind rtcxpc_core rtcxpc_props #(.UPDATE_LEAD(UPDATE_LEAD), .RAM_BYTES(RAM_BYTES)) u_props (
    .clock, .rst, .rd_n, .cs_n, .ad_oe_n, .osc_32k, .square_wave_out, .update_request,
    .update_start, .ram_clear_in, .ram_clear_busy, .main_supply_ok, .irq_oe_n,
    .power_enable_out, .irq_out
);
